// >>> dv/liu_serial_host_port_bench.sv
// Self-checking bench of the serial host port
`timescale 1ns/100ps
module liu_serial_host_port_bench;
  logic       clk_sys = 1'b0;
  logic       rst, mode, tb_mon, tb_los, sdo_last;
  logic       sclk, cs_n, serial_in_pin, sdo_line, sdo_out, sdo_oe, irq_line, irq_n, irq_oe;
  logic       host_mode, rx_en, rx_mon, los_mute, tx_inv, rx_inv, wr_stb;
  logic [6:0] wr_addr;
  logic [7:0] wr_data, irq_ev;
  int         n_errors = 0;
  int         tests_run = 0;

  always #5 clk_sys = ~clk_sys;

  // Released serial out shows the inverse of its last bit in host mode, tb_mon in hardware mode
  always @(sdo_out or sdo_oe) if (sdo_oe === 1'b1) sdo_last = sdo_out;
  assign sdo_line = sdo_oe ? sdo_out : (mode ? ~sdo_last : tb_mon);
  assign irq_line = irq_oe ? irq_n : tb_los;

  lsp_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(serial_in_pin), .i_sdo(sdo_line));

  lsp_host_port dut (
    .I_CLK_SYS(clk_sys), .I_RST(rst), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_SERIAL_IN_PIN(serial_in_pin), .I_SERIAL_OUT_PIN(sdo_line), .O_SERIAL_OUT_PIN(sdo_out),
    .O_SERIAL_OUT_PIN_OE(sdo_oe), .I_IRQ_PIN(irq_line), .O_IRQ_N_PIN(irq_n),
    .O_IRQ_PIN_OE(irq_oe), .I_CONTROL_MODE_SELECT(mode), .I_IRQ_EVENT(irq_ev),
    .O_HOST_MODE(host_mode), .O_RECEIVER_ENABLE(rx_en), .O_RECEIVER_MONITOR_SELECT(rx_mon),
    .O_LOS_MUTE(los_mute), .O_TX_CLOCK_INVERT(tx_inv), .O_RX_CLOCK_INVERT(rx_inv),
    .O_WR_STB(wr_stb), .O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data));

  // ==========================================================================
  // Shared helpers
  function automatic logic [7:0] ctl();
    return {2'b00, host_mode, rx_inv, tx_inv, los_mute, rx_mon, rx_en};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    logic       seen;
    seen = 1'b0;
    fork
      host.frame(1'b0, a, d, 16, unused);
      for (int k = 0; k < 250 && !seen; k++) begin
        @(posedge clk_sys);
        #1;
        seen = (wr_stb === 1'b1);
      end
    join
    chk({7'h00, seen}, 8'h01);
    chk({1'b0, wr_addr}, {1'b0, a});
    chk(wr_data, d);
    tick(2);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] got;
    host.frame(lsp_pkg::RW_READ, a, 8'h00, 16, got);
    chk(got, e);
    chk({7'h00, sdo_oe}, 8'h00);
    tick(2);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk(ctl(), 8'h21);
    chk({6'h00, irq_n, irq_oe}, 8'h03);
    rd(lsp_pkg::OFS_CTRL, lsp_pkg::RST_CTRL);
    rd(lsp_pkg::OFS_IRQ_EN, lsp_pkg::RST_IRQ_EN);
    rd(7'h05, lsp_pkg::RST_GEN);
  endtask

  task automatic t_rw();
    wr(lsp_pkg::OFS_CTRL, 8'h1e);
    tick(10);
    chk(ctl(), 8'h3e);
    rd(lsp_pkg::OFS_CTRL, 8'h1e);
    wr(7'h0f, 8'ha5);
    wr(7'h03, 8'h5a);
    rd(7'h0f, 8'ha5);
    rd(7'h03, 8'h5a);
    wr(lsp_pkg::OFS_LIMIT, 8'hff);
    rd(lsp_pkg::OFS_LIMIT, 8'h00);
  endtask

  task automatic t_abort();
    logic [7:0] unused;
    logic [7:0] got;
    host.frame(1'b0, lsp_pkg::OFS_CTRL, 8'h00, 9, unused);
    tick(10);
    chk({1'b0, wr_addr}, {1'b0, lsp_pkg::OFS_LIMIT});
    chk(ctl(), 8'h3e);
    host.frame(1'b0, 7'h04, 8'h3c, 18, unused);
    tick(10);
    chk({1'b0, wr_addr}, 8'h04);
    chk(wr_data, 8'h3c);
    host.frame(lsp_pkg::RW_READ, 7'h04, 8'h00, 18, got);
    chk(got, 8'h3c);
    chk({7'h00, sdo_oe}, 8'h00);
    tick(2);
  endtask

  task automatic t_irq();
    wr(lsp_pkg::OFS_IRQ_EN, 8'h01);
    irq_ev = 8'h02;
    tick(1);
    irq_ev = 8'h00;
    tick(5);
    chk({7'h00, irq_n}, 8'h01);
    irq_ev = 8'h01;
    tick(1);
    irq_ev = 8'h00;
    tick(1);
    chk({7'h00, irq_n}, 8'h00);
    tick(20);
    chk({7'h00, irq_n}, 8'h00);
    rd(lsp_pkg::OFS_IRQ_STAT, 8'h03);
    wr(lsp_pkg::OFS_IRQ_STAT, 8'h03);
    tick(5);
    chk({7'h00, irq_n}, 8'h01);
  endtask

  task automatic t_hw();
    logic [4:0] pat [2];
    pat[0] = 5'h15;
    pat[1] = 5'h0a;
    mode = 1'b0;
    tick(12);
    chk({5'h00, host_mode, sdo_oe, irq_oe}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      tb_mon = pat[i][1];
      tb_los = pat[i][2];
      host.levels(pat[i][3], pat[i][4], pat[i][0]);
      tick(12);
      chk(ctl(), {3'b000, pat[i]});
    end
    host.levels(1'b0, 1'b1, 1'b0);
    mode = 1'b1;
    tick(12);
    chk(ctl(), 8'h3e);
  endtask

  task automatic t_rst2();
    rst = 1'b1;
    tick(5);
    rst = 1'b0;
    tick(12);
    chk(ctl(), 8'h21);
    chk({1'b0, wr_addr}, 8'h00);
    rd(lsp_pkg::OFS_CTRL, lsp_pkg::RST_CTRL);
  endtask

  // ==========================================================================
  // Verdict and sequence
  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end

  initial begin
    rst      = 1'b1;
    mode     = 1'b1;
    irq_ev   = 8'h00;
    tb_mon   = 1'b0;
    tb_los   = 1'b1;
    sdo_last = 1'b0;
    tick(5);
    rst = 1'b0;
    tick(12);
    t_reset();
    t_rw();
    t_abort();
    t_irq();
    t_hw();
    t_rst2();
    end_of_test();
  end
endmodule

// >>> dv/lsp_host_model.sv
// Host side model that frames serial transfers on the link
`timescale 1ns/100ps
module lsp_host_model (
  // Link outputs
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi,
  // Link input
  input  wire logic i_sdo
);
  // Half period that keeps the serial clock at ten megahertz
  localparam int HALF_NS = 50;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end

  // ==========================================================================
  // One frame; fewer than sixteen edges aborts it, extra edges trail it
  task automatic frame(input logic rw, input logic [6:0] addr, input logic [7:0] wdata,
                       input int n_edge, output logic [7:0] rdata);
    logic [15:0] word;
    word  = {rw, addr, wdata};
    rdata = 8'h00;
    #3.7;
    o_cs_n = 1'b0;
    for (int i = 0; i < n_edge; i++) begin
      o_sdi = word[15];
      word  = {word[14:0], 1'b0};
      #(HALF_NS) o_sclk = 1'b1;
      if (i >= 8 && i < 16) begin
        rdata = {rdata[6:0], i_sdo};
      end
      #(HALF_NS) o_sclk = 1'b0;
    end
    #(HALF_NS) o_cs_n = 1'b1;
    // Released line shows no stale bit
    o_sdi = ~o_sdi;
  endtask

  // Static levels for hardware mode
  task automatic levels(input logic sc, input logic cs, input logic di);
    o_sclk = sc;
    o_cs_n = cs;
    o_sdi  = di;
  endtask
endmodule

// >>> hw/lsp_host_port.sv
// Serial host port: frame engine on the serial clock, control on the system clock
//
// What this block does
// (R01) Host keeps chip select low through a whole frame, high otherwise.
// (R02) Host gives exactly sixteen serial clock periods per frame.
// (R03) Serial input is sampled on every rising serial clock edge.
// (R04) Read data leaves on serial output, changing on falling edges.
// (R05) Serial output goes high impedance once a read frame ends.
// (R06) Input stream holds read/write bit, register address, and write data.
// (R07) Host keeps the serial clock at or below ten megahertz.
// (R08) In host mode interrupt pin idles high, low on enabled event.
// (R09) Interrupt pin stays low until the host services the event.
// (R10) Reset returns every command register to its default value.
// (R11) Hardware mode turns the five port pins into control inputs.
// (R12) Mode pin high picks host mode, low picks hardware mode.
// (R13) Frame: read/write bit, seven address bits, then eight data bits.
`timescale 1ns/100ps
module lsp_host_port (
  // System clock and reset
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST,
  // Serial link
  input  wire logic       I_SCLK,
  input  wire logic       I_CS_N,
  input  wire logic       I_SERIAL_IN_PIN,
  input  wire logic       I_SERIAL_OUT_PIN,
  output logic            O_SERIAL_OUT_PIN,
  output logic            O_SERIAL_OUT_PIN_OE,
  // Interrupt pin
  input  wire logic       I_IRQ_PIN,
  output logic            O_IRQ_N_PIN,
  output logic            O_IRQ_PIN_OE,
  // Mode strap
  input  wire logic       I_CONTROL_MODE_SELECT,
  // Core events
  input  wire logic [7:0] I_IRQ_EVENT,
  // Core controls
  output logic            O_HOST_MODE,
  output logic            O_RECEIVER_ENABLE,
  output logic            O_RECEIVER_MONITOR_SELECT,
  output logic            O_LOS_MUTE,
  output logic            O_TX_CLOCK_INVERT,
  output logic            O_RX_CLOCK_INVERT,
  // Write notices
  output logic            O_WR_STB,
  output logic [6:0]      O_WR_ADDR,
  output logic [7:0]      O_WR_DATA
);

  // ==========================================================================
  // Link domain: frame engine
  logic                 rst_frame;
  lsp_pkg::lsp_frame_t  state_ff;
  lsp_pkg::lsp_frame_t  nxt_state;
  logic [4:0]           cnt_ff;
  logic [4:0]           nxt_cnt;
  logic [7:0]           cmd_sr_ff;
  logic [7:0]           nxt_cmd_sr;
  logic [7:0]           wdat_sr_ff;
  logic [7:0]           nxt_wdat_sr;
  logic [7:0]           rd_sr_ff;
  logic [7:0]           nxt_rd_sr;
  logic [6:0]           rd_addr;
  logic [7:0]           stat_link;
  logic                 is_read;
  logic [7:0]           regs_ff [lsp_pkg::REG_NUM];
  logic [7:0]           stat_ff;
  logic                 host_mode;

  assign rst_frame = I_RST | I_CS_N;
  assign is_read   = (cmd_sr_ff[7] == lsp_pkg::RW_READ);
  assign rd_addr   = {cmd_sr_ff[5:0], I_SERIAL_IN_PIN};
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff + lsp_pkg::CNT_INC;
    nxt_cmd_sr  = cmd_sr_ff;
    nxt_wdat_sr = wdat_sr_ff;
    nxt_rd_sr   = rd_sr_ff;
    unique case (state_ff)
      lsp_pkg::LSP_ST_CMD: begin
        nxt_cmd_sr = {cmd_sr_ff[6:0], I_SERIAL_IN_PIN}; // R03 R06 R13
        if (cnt_ff == lsp_pkg::CNT_ADDR_LAST) begin
          nxt_state = lsp_pkg::LSP_ST_DATA;
          if (rd_addr == lsp_pkg::OFS_IRQ_STAT) begin
            nxt_rd_sr = stat_link;
          end else if (rd_addr < lsp_pkg::OFS_LIMIT) begin
            nxt_rd_sr = regs_ff[rd_addr[3:0]];
          end else begin
            nxt_rd_sr = 8'h00;
          end
        end
      end
      lsp_pkg::LSP_ST_DATA: begin
        nxt_wdat_sr = {wdat_sr_ff[6:0], I_SERIAL_IN_PIN}; // R03 R13
        if (cnt_ff == lsp_pkg::CNT_DATA_LAST) begin
          nxt_state = lsp_pkg::LSP_ST_DONE;
        end
      end
      lsp_pkg::LSP_ST_DONE: begin
        nxt_cnt = cnt_ff;
      end
    endcase
  end
  always_ff @(posedge I_SCLK or posedge rst_frame) begin
    if (rst_frame) begin
      state_ff   <= lsp_pkg::LSP_ST_CMD;
      cnt_ff     <= 5'h00;
      cmd_sr_ff  <= 8'h00;
      wdat_sr_ff <= 8'h00;
      rd_sr_ff   <= 8'h00;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      cmd_sr_ff  <= nxt_cmd_sr;
      wdat_sr_ff <= nxt_wdat_sr;
      rd_sr_ff   <= nxt_rd_sr;
    end
  end

  // ==========================================================================
  // Link domain: command registers and write hand-off
  logic [7:0] nxt_regs [lsp_pkg::REG_NUM];
  logic       wr_commit;
  logic [7:0] wr_value;
  logic       wr_tgl_ff;
  logic       nxt_wr_tgl;
  logic [6:0] wr_addr_ff;
  logic [6:0] nxt_wr_addr;
  logic [7:0] wr_data_ff;
  logic [7:0] nxt_wr_data;

  assign wr_value  = {wdat_sr_ff[6:0], I_SERIAL_IN_PIN};
  assign wr_commit = (state_ff == lsp_pkg::LSP_ST_DATA) && !is_read && !rst_frame &&
                     (cnt_ff == lsp_pkg::CNT_DATA_LAST);
  always_comb begin
    nxt_regs    = regs_ff;
    nxt_wr_tgl  = wr_tgl_ff;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    if (wr_commit) begin
      if (cmd_sr_ff[6:0] < lsp_pkg::OFS_LIMIT) begin
        nxt_regs[cmd_sr_ff[3:0]] = wr_value; // R06
      end
      nxt_wr_tgl  = ~wr_tgl_ff;
      nxt_wr_addr = cmd_sr_ff[6:0];
      nxt_wr_data = wr_value;
    end
  end
  always_ff @(posedge I_SCLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < lsp_pkg::REG_NUM; i++) begin
        regs_ff[i] <= lsp_pkg::RST_GEN; // R10
      end
      regs_ff[lsp_pkg::OFS_CTRL[3:0]]   <= lsp_pkg::RST_CTRL;
      regs_ff[lsp_pkg::OFS_IRQ_EN[3:0]] <= lsp_pkg::RST_IRQ_EN;
      wr_tgl_ff  <= 1'b0;
      wr_addr_ff <= 7'h00;
      wr_data_ff <= 8'h00;
    end else begin
      regs_ff    <= nxt_regs;
      wr_tgl_ff  <= nxt_wr_tgl;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
    end
  end

  // Interrupt status seen from the link side
  lsp_sync #(.WIDTH(lsp_pkg::IRQ_W), .RST_VAL(8'h00)) u_stat_sync (
    .i_clk   (I_SCLK),
    .i_rst   (I_RST),
    .i_async (stat_ff),
    .o_level (stat_link)
  );

  // ==========================================================================
  // Link domain: serial output on falling edges
  logic sdo_ff;
  logic nxt_sdo;
  logic sdo_oe_ff;
  logic nxt_sdo_oe;
  always_comb begin
    nxt_sdo    = sdo_ff;
    nxt_sdo_oe = 1'b0; // R05
    if ((state_ff == lsp_pkg::LSP_ST_DATA) && is_read) begin
      nxt_sdo    = rd_sr_ff[3'h7 - cnt_ff[2:0]]; // R04
      nxt_sdo_oe = 1'b1;
    end
  end
  always_ff @(negedge I_SCLK or posedge rst_frame) begin
    if (rst_frame) begin
      sdo_ff    <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else begin
      sdo_ff    <= nxt_sdo;
      sdo_oe_ff <= nxt_sdo_oe;
    end
  end

  assign O_SERIAL_OUT_PIN    = sdo_ff;
  assign O_SERIAL_OUT_PIN_OE = sdo_oe_ff & host_mode; // R05 R11

  // ==========================================================================
  // System domain: pin levels and write notices
  logic [6:0] sync_lvl;
  logic       wr_evt;
  logic       wr_seen_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] irq_en_ff;
  logic [7:0] nxt_irq_en;
  logic [7:0] nxt_stat;
  logic [7:0] stat_clr;
  logic       irq_ff;
  logic       nxt_irq;
  logic [4:0] core_ff;
  logic [4:0] nxt_core;
  logic       wr_stb_ff;
  logic [6:0] wr_addr_out_ff;
  logic [7:0] wr_data_out_ff;
  logic [6:0] nxt_wr_addr_out;
  logic [7:0] nxt_wr_data_out;

  lsp_sync #(.WIDTH(lsp_pkg::SYNC_W), .RST_VAL(lsp_pkg::SYNC_RST)) u_pin_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_RST),
    .i_async ({I_CONTROL_MODE_SELECT, I_SERIAL_OUT_PIN, I_SERIAL_IN_PIN, I_IRQ_PIN,
               I_CS_N, I_SCLK, wr_tgl_ff}),
    .o_level (sync_lvl)
  );

  assign host_mode = sync_lvl[6];
  assign wr_evt    = (sync_lvl[0] != wr_seen_ff);
  always_comb begin
    nxt_ctrl        = ctrl_ff;
    nxt_irq_en      = irq_en_ff;
    stat_clr        = 8'h00;
    nxt_wr_addr_out = wr_addr_out_ff;
    nxt_wr_data_out = wr_data_out_ff;
    if (wr_evt) begin
      nxt_wr_addr_out = wr_addr_ff;
      nxt_wr_data_out = wr_data_ff;
      if (wr_addr_ff == lsp_pkg::OFS_CTRL) begin
        nxt_ctrl = wr_data_ff;
      end
      if (wr_addr_ff == lsp_pkg::OFS_IRQ_EN) begin
        nxt_irq_en = wr_data_ff;
      end
      if (wr_addr_ff == lsp_pkg::OFS_IRQ_STAT) begin
        stat_clr = wr_data_ff;
      end
    end
    nxt_stat = (stat_ff & ~stat_clr) | I_IRQ_EVENT; // R09
    nxt_irq  = host_mode && ((stat_ff & irq_en_ff) != 8'h00); // R08
    if (host_mode) begin
      nxt_core = {ctrl_ff[lsp_pkg::BIT_RCLK_INV], ctrl_ff[lsp_pkg::BIT_TCLK_INV],
                  ctrl_ff[lsp_pkg::BIT_LOS_MUTE], ctrl_ff[lsp_pkg::BIT_RX_MON],
                  ctrl_ff[lsp_pkg::BIT_RX_ON]};
    end else begin
      nxt_core = {sync_lvl[2], sync_lvl[1], sync_lvl[3], sync_lvl[5], sync_lvl[4]}; // R11
    end
  end
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      wr_seen_ff     <= 1'b0;
      ctrl_ff        <= lsp_pkg::RST_CTRL; // R10
      irq_en_ff      <= lsp_pkg::RST_IRQ_EN;
      stat_ff        <= 8'h00;
      irq_ff         <= 1'b0;
      core_ff        <= 5'h00;
      wr_stb_ff      <= 1'b0;
      wr_addr_out_ff <= 7'h00;
      wr_data_out_ff <= 8'h00;
    end else begin
      wr_seen_ff     <= sync_lvl[0];
      ctrl_ff        <= nxt_ctrl;
      irq_en_ff      <= nxt_irq_en;
      stat_ff        <= nxt_stat;
      irq_ff         <= nxt_irq;
      core_ff        <= nxt_core;
      wr_stb_ff      <= wr_evt;
      wr_addr_out_ff <= nxt_wr_addr_out;
      wr_data_out_ff <= nxt_wr_data_out;
    end
  end
  assign O_IRQ_N_PIN               = ~irq_ff; // R08 R09
  assign O_IRQ_PIN_OE              = host_mode; // R11
  assign O_HOST_MODE               = host_mode;
  assign O_RECEIVER_ENABLE         = core_ff[0];
  assign O_RECEIVER_MONITOR_SELECT = core_ff[1];
  assign O_LOS_MUTE                = core_ff[2];
  assign O_TX_CLOCK_INVERT         = core_ff[3];
  assign O_RX_CLOCK_INVERT         = core_ff[4];
  assign O_WR_STB                  = wr_stb_ff;
  assign O_WR_ADDR                 = wr_addr_out_ff;
  assign O_WR_DATA                 = wr_data_out_ff;

  // ==========================================================================
  // Checks
  AST_SDI_SAMPLE: assert property (@(posedge I_SCLK) disable iff (rst_frame) // R03
    (state_ff == lsp_pkg::LSP_ST_CMD) |=> (cmd_sr_ff[0] == $past(I_SERIAL_IN_PIN)))
    else $error("serial input not sampled on rising edge");
  AST_SDO_BIT: assert property (@(posedge I_SCLK) disable iff (rst_frame) // R04
    ((state_ff == lsp_pkg::LSP_ST_DATA) && is_read) |->
      (sdo_oe_ff && (sdo_ff == rd_sr_ff[3'h7 - cnt_ff[2:0]]) &&
       ((cnt_ff == 5'h08) || $stable(rd_sr_ff))))
    else $error("read bit on serial output is wrong");
  AST_SDO_RELEASE: assert property (@(posedge I_SCLK) disable iff (rst_frame) // R05
    (state_ff == lsp_pkg::LSP_ST_DONE) |-> !sdo_oe_ff)
    else $error("serial output still driven after frame");
  AST_WR_COMMIT: assert property (@(posedge I_SCLK) disable iff (I_RST || I_CS_N) // R06
    wr_commit |=> ((wr_data_ff == $past(wr_value)) && (wr_tgl_ff != $past(wr_tgl_ff))))
    else $error("write frame not committed");
  AST_FRAME_SHAPE: assert property (@(posedge I_SCLK) disable iff (rst_frame) // R13
    (state_ff == lsp_pkg::LSP_ST_DATA) |-> (cnt_ff >= 5'h08 && cnt_ff <= lsp_pkg::CNT_DATA_LAST))
    else $error("data phase outside bits eight to fifteen");
  AST_IRQ_ASSERT: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // R08
    (host_mode && ((stat_ff & irq_en_ff) != 8'h00)) |=> !O_IRQ_N_PIN)
    else $error("enabled event did not pull interrupt low");
  AST_IRQ_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // R09
    (!O_IRQ_N_PIN && !wr_evt && !$past(wr_evt)) |=> (!O_IRQ_N_PIN || !$past(host_mode)))
    else $error("interrupt released without service");
  AST_SET_WINS: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // R09
    (I_IRQ_EVENT != 8'h00) |=> ((stat_ff & $past(I_IRQ_EVENT)) == $past(I_IRQ_EVENT)))
    else $error("event lost against clear");
  AST_RESET_DEFAULT: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // R10
    $past(I_RST) |-> ((ctrl_ff == lsp_pkg::RST_CTRL) && (irq_en_ff == lsp_pkg::RST_IRQ_EN)))
    else $error("command registers not at defaults after reset");
  AST_HW_MAP: assert property (@(posedge I_CLK_SYS) disable iff (I_RST) // R11
    !host_mode |=> ((O_RECEIVER_ENABLE == $past(sync_lvl[4])) &&
                    (O_LOS_MUTE == $past(sync_lvl[3])) && !O_SERIAL_OUT_PIN_OE))
    else $error("hardware mode pin mapping wrong");
  COV_READ: cover property (@(posedge I_SCLK) disable iff (rst_frame)
    (state_ff == lsp_pkg::LSP_ST_DONE) && is_read);
  COV_WRITE: cover property (@(posedge I_SCLK) disable iff (I_RST) wr_commit);
  COV_IRQ: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) $fell(O_IRQ_N_PIN));
  COV_HW: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) !host_mode ##1 host_mode);
endmodule

// >>> hw/lsp_pkg.sv
// Constants and types of the serial host port
package lsp_pkg;

  // ==========================================================================
  // Frame layout
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CNT_W         = 5;
  localparam int unsigned REG_NUM       = 16;
  localparam int unsigned IRQ_W         = 8;
  localparam int unsigned SYNC_W        = 7;
  localparam logic [4:0]  CNT_ADDR_LAST = 5'h07;
  localparam logic [4:0]  CNT_DATA_LAST = 5'h0f;
  localparam logic [4:0]  CNT_INC       = 5'h01;
  localparam logic        RW_READ       = 1'b1;

  // ==========================================================================
  // Command register offsets and values after reset
  localparam logic [6:0]  OFS_CTRL      = 7'h00;
  localparam logic [6:0]  OFS_IRQ_EN    = 7'h01;
  localparam logic [6:0]  OFS_IRQ_STAT  = 7'h02;
  localparam logic [6:0]  OFS_LIMIT     = 7'h10;
  localparam logic [7:0]  RST_CTRL      = 8'h01;
  localparam logic [7:0]  RST_IRQ_EN    = 8'h00;
  localparam logic [7:0]  RST_GEN       = 8'h00;
  localparam logic [6:0]  SYNC_RST      = 7'h00;

  // ==========================================================================
  // Control register fields
  localparam int unsigned BIT_RX_ON     = 0;
  localparam int unsigned BIT_RX_MON    = 1;
  localparam int unsigned BIT_LOS_MUTE  = 2;
  localparam int unsigned BIT_TCLK_INV  = 3;
  localparam int unsigned BIT_RCLK_INV  = 4;

  // ==========================================================================
  // Frame phases
  typedef enum logic [2:0] {
    LSP_ST_CMD  = 3'b001,
    LSP_ST_DATA = 3'b010,
    LSP_ST_DONE = 3'b100
  } lsp_frame_t;

endpackage

// >>> hw/lsp_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module lsp_sync #(
  parameter int unsigned     WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;

  // A bit moves only once stages two and three agree
  always_comb begin
    nxt_level = (stage2_ff & stage3_ff) | ((stage2_ff ^ stage3_ff) & level_ff);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff   <= RST_VAL;
      stage2_ff <= RST_VAL;
      stage3_ff <= RST_VAL;
      level_ff  <= RST_VAL;
    end else begin
      meta_ff   <= i_async;
      stage2_ff <= meta_ff;
      stage3_ff <= stage2_ff;
      level_ff  <= nxt_level;
    end
  end

  assign o_level = level_ff;

endmodule
